/* File: design/gptuc_timer.sv */
// gptuc_timer: 16-bit general-purpose timer, up-counting modes, AXI4-Lite registers
// Notes on behaviour
// - counting behaviour chosen by the mode field of the timer control register
// - enable bit 6 clear halts counting and clears the prescale counter to zero
// - counting begins right after enable is set, no start-up delay
// - stop/hold freezes counter, compare output and prescale counter
// - single up: count to period, next scaled clock clears counter and enable
// - period flag two clocks after match; adc start then if selected
// - underflow flag two clocks after counter becomes zero; adc start if selected
// - overflow flag two clocks after counter equals all ones
// - single up period from zero lasts period plus one scaled clocks
// - start above period: count to all ones, wrap, finish as from zero
// - start equal to period: period flag, clear, underflow flag, end at once
// - start below period: count to period, finish as if started there
// - up modes report direction bit as one, external direction pin ignored
// - continuous up: at period match clear and start anew, no lost clock
// - continuous up periods span period plus one scaled clocks
// - continuous up: start above period wraps through all ones to zero
// - continuous up: start equal period flags both events, continues from zero
// - mode field bits 11-13: 000 stop, 001 single up, 010 continuous up
// - clock source bits 4-5 (00 internal); prescale bits 8-10 (001 divide-by-two)
// - other control fields: own period, compare enable, reload, own enable, emulation
// - global control: two-bit compare polarity, bit 6 enables compare outputs
`timescale 1ns/1ps
module gptuc_timer
  import gptuc_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // external inputs
  input wire logic external_clock,
  input wire logic external_direction_pin,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer outputs
  output logic compare_out,
  output logic adc_start
);
  import gptuc_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = d[7:0];
    if (strb[1]) r[15:8] = d[15:8];
    return r;
  endfunction : merge16

  // ==========================================================
  // state
  logic [15:0] timer_control_reg, next_timer_control_reg;
  logic [15:0] global_timer_control_reg, next_global_timer_control_reg;
  logic [15:0] counter_value_reg, next_counter_value_reg;
  logic [15:0] period_reg, next_period_reg;
  logic [15:0] compare_reg, next_compare_reg;
  logic [6:0] presc_cnt, next_presc_cnt;
  logic ext_q, next_ext_q;
  logic [2:0] status, next_status;
  logic [2:0] ev_d1, ev_prev, next_ev_d1;
  logic end_q, next_end_q;
  logic cmp_level, next_cmp_level;
  logic adc_q, next_adc_q;
  gptuc_wstate_t wstate, next_wstate;
  logic aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] bresp_q, next_bresp_q;
  logic rvalid_q, next_rvalid_q;
  logic [31:0] rdata_q, next_rdata_q;
  logic [1:0] rresp_q, next_rresp_q;
  logic [6:0] presc_limit;
  logic tick, ext_rise, enabled, up_mode, do_write, do_read, live;
  logic [2:0] mode;
  logic [2:0] ev_now;

  // ==========================================================
  // clocking and scaled tick
  assign mode = timer_control_reg[CTL_MODE_LO +: 3];
  assign enabled = timer_control_reg[CTL_ENABLE];
  assign up_mode = (mode == MODE_SINGLE_UP) || (mode == MODE_CONT_UP);
  // divide ratio 2^n; bit 0 of 8-10 selects divide-by-two
  assign presc_limit = 7'((8'h01 << timer_control_reg[CTL_PRESC_LO +: 3]) - 8'h01);
  assign ext_rise = external_clock && !ext_q;
  // input clock edge: every mclk when internal, else external rising edge
  assign tick = enabled && up_mode && (presc_cnt == presc_limit) &&
                ((timer_control_reg[CTL_CLKSRC_LO +: 2] == CLK_INTERNAL) || ext_rise);
  assign do_write = (wstate == GPTUC_W_IDLE) && aw_hold && w_hold;
  assign do_read = s_axi_arvalid && !rvalid_q;
  // cycle after a single up end still live, else its final zero would go unflagged
  assign live = (enabled && up_mode) || end_q;
  // events seen by the current counter value
  assign ev_now[STAT_PERIOD] = live && (counter_value_reg == period_reg);
  assign ev_now[STAT_UNDERFLOW] = live && (counter_value_reg == 16'h0000);
  assign ev_now[STAT_OVERFLOW] = live && (counter_value_reg == COUNT_ALL_ONES);

  // ==========================================================
  // timer engine next state
  always_comb
  begin
    next_timer_control_reg = timer_control_reg;
    next_counter_value_reg = counter_value_reg;
    next_presc_cnt = presc_cnt;
    next_ext_q = external_clock;
    next_cmp_level = cmp_level;
    next_end_q = 1'b0;
    if (!enabled)
    begin
      next_presc_cnt = 7'h00;
    end
    else if (mode == MODE_STOP)
    begin
      next_presc_cnt = presc_cnt;
    end
    else if (up_mode && ((timer_control_reg[CTL_CLKSRC_LO +: 2] == CLK_INTERNAL) || ext_rise))
    begin
      next_presc_cnt = (presc_cnt == presc_limit) ? 7'h00 : 7'(presc_cnt + 7'h01);
    end
    if (tick)
    begin
      if (counter_value_reg == period_reg)
      begin
        next_counter_value_reg = 16'h0000;
        if (mode == MODE_SINGLE_UP)
        begin
          next_timer_control_reg[CTL_ENABLE] = 1'b0;
          next_end_q = 1'b1;
        end
      end
      else
      begin
        // wraps through all ones when above period; one step per tick
        next_counter_value_reg = 16'(counter_value_reg + 16'h0001);
      end
    end
    // compare output: set on compare match, cleared on period match
    if (timer_control_reg[CTL_CMP_EN] && enabled && up_mode)
    begin
      if (ev_now[STAT_PERIOD]) next_cmp_level = 1'b0;
      else if (counter_value_reg == compare_reg) next_cmp_level = 1'b1;
    end
    if (do_write && (aw_addr[7:0] == OFS_TIMER_CONTROL))
    begin
      next_timer_control_reg = merge16(timer_control_reg, w_data, w_strb);
    end
    if (do_write && (aw_addr[7:0] == OFS_COUNTER))
    begin
      next_counter_value_reg = merge16(counter_value_reg, w_data, w_strb);
    end
  end

  // ==========================================================
  // event pipeline, flags and adc start
  always_comb
  begin
    // rising edge only: a count held over prescaled cycles flags once
    next_ev_d1 = ev_now & ~ev_prev;
    next_status = status;
    if (do_write && (aw_addr[7:0] == OFS_STATUS))
    begin
      next_status = status & ~w_data[2:0];
    end
    // set wins over a clear in the same cycle; flag shows two edges after the event
    next_status = next_status | ev_d1;
    next_adc_q = 1'b0;
    case (global_timer_control_reg[GCTL_ADC_LO +: 2])
      ADC_PERIOD: next_adc_q = ev_d1[STAT_PERIOD];
      ADC_UNDERFLOW: next_adc_q = ev_d1[STAT_UNDERFLOW];
      default: next_adc_q = 1'b0;
    endcase
  end

  // ==========================================================
  // axi4-lite slave next state
  always_comb
  begin
    next_global_timer_control_reg = global_timer_control_reg;
    next_period_reg = period_reg;
    next_compare_reg = compare_reg;
    next_wstate = wstate;
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bresp_q = bresp_q;
    next_rvalid_q = rvalid_q;
    next_rdata_q = rdata_q;
    next_rresp_q = rresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    case (wstate)
      GPTUC_W_IDLE:
      begin
        if (do_write)
        begin
          next_wstate = GPTUC_W_RESP;
          next_aw_hold = 1'b0;
          next_w_hold = 1'b0;
          next_bresp_q = AXI_OKAY;
          case (aw_addr[7:0])
            OFS_GLOBAL_CONTROL: next_global_timer_control_reg =
              (global_timer_control_reg & ~GCTL_WRITE_MASK) |
              (merge16(global_timer_control_reg, w_data, w_strb) & GCTL_WRITE_MASK);
            OFS_PERIOD: next_period_reg = merge16(period_reg, w_data, w_strb);
            OFS_TIMER_CONTROL, OFS_COUNTER, OFS_STATUS: next_bresp_q = AXI_OKAY;
            OFS_COMPARE: next_compare_reg = merge16(compare_reg, w_data, w_strb);
            default: next_bresp_q = AXI_SLVERR;
          endcase
        end
      end
      GPTUC_W_RESP:
      begin
        if (s_axi_bready) next_wstate = GPTUC_W_IDLE;
      end
      default: next_wstate = GPTUC_W_IDLE;
    endcase
    // direction bit always up in these modes, pin ignored
    next_global_timer_control_reg[GCTL_DIR] = 1'b1;
    if (rvalid_q && s_axi_rready) next_rvalid_q = 1'b0;
    if (do_read)
    begin
      next_rvalid_q = 1'b1;
      next_rresp_q = AXI_OKAY;
      next_rdata_q = 32'h0000_0000;
      case (s_axi_araddr[7:0])
        OFS_TIMER_CONTROL: next_rdata_q[15:0] = timer_control_reg;
        OFS_GLOBAL_CONTROL: next_rdata_q[15:0] = global_timer_control_reg;
        OFS_COUNTER: next_rdata_q[15:0] = counter_value_reg;
        OFS_PERIOD: next_rdata_q[15:0] = period_reg;
        OFS_STATUS: next_rdata_q[2:0] = status;
        OFS_COMPARE: next_rdata_q[15:0] = compare_reg;
        default: next_rresp_q = AXI_SLVERR;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      timer_control_reg <= RST_TIMER_CONTROL;
      global_timer_control_reg <= RST_GLOBAL_CONTROL;
      counter_value_reg <= RST_COUNTER;
      period_reg <= RST_PERIOD;
      compare_reg <= RST_COUNTER;
      presc_cnt <= 7'h00;
      ext_q <= 1'b0;
      status <= 3'h0;
      ev_d1 <= 3'h0;
      ev_prev <= 3'h0;
      end_q <= 1'b0;
      cmp_level <= 1'b0;
      adc_q <= 1'b0;
      wstate <= GPTUC_W_IDLE;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bresp_q <= AXI_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= AXI_OKAY;
    end
    else
    begin
      timer_control_reg <= next_timer_control_reg;
      global_timer_control_reg <= next_global_timer_control_reg;
      counter_value_reg <= next_counter_value_reg;
      period_reg <= next_period_reg;
      compare_reg <= next_compare_reg;
      presc_cnt <= next_presc_cnt;
      ext_q <= next_ext_q;
      status <= next_status;
      ev_d1 <= next_ev_d1;
      ev_prev <= ev_now;
      end_q <= next_end_q;
      cmp_level <= next_cmp_level;
      adc_q <= next_adc_q;
      wstate <= next_wstate;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bresp_q <= next_bresp_q;
      rvalid_q <= next_rvalid_q;
      rdata_q <= next_rdata_q;
      rresp_q <= next_rresp_q;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = !aw_hold && (wstate == GPTUC_W_IDLE);
  assign s_axi_wready = !w_hold && (wstate == GPTUC_W_IDLE);
  assign s_axi_bvalid = (wstate == GPTUC_W_RESP);
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign adc_start = adc_q;
  always_comb
  begin
    compare_out = 1'b0;
    if (global_timer_control_reg[GCTL_CMP_OUT_EN])
    begin
      case (global_timer_control_reg[GCTL_POL_LO +: 2])
        POL_ACTIVE_LOW: compare_out = !cmp_level;
        POL_ACTIVE_HIGH: compare_out = cmp_level;
        POL_FORCED_LOW: compare_out = 1'b0;
        default: compare_out = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // checks
  AST_PERIOD_FLAG: assert property (@(posedge mclk) disable iff (reset)
    $rose(ev_now[STAT_PERIOD]) |-> ##2 status[STAT_PERIOD])
    else $error("period flag not set two clocks after match");
  AST_UNDER_FLAG: assert property (@(posedge mclk) disable iff (reset)
    $rose(ev_now[STAT_UNDERFLOW]) |-> ##2 status[STAT_UNDERFLOW])
    else $error("underflow flag late");
  AST_OVER_FLAG: assert property (@(posedge mclk) disable iff (reset)
    $rose(ev_now[STAT_OVERFLOW]) |-> ##2 status[STAT_OVERFLOW])
    else $error("overflow flag late");
  AST_SINGLE_END: assert property (@(posedge mclk) disable iff (reset)
    (tick && mode == MODE_SINGLE_UP && counter_value_reg == period_reg && !do_write)
    |=> (counter_value_reg == 16'h0000 && !enabled))
    else $error("single up did not end");
  AST_CONT_WRAP: assert property (@(posedge mclk) disable iff (reset)
    (tick && mode == MODE_CONT_UP && counter_value_reg == period_reg && !do_write)
    |=> (counter_value_reg == 16'h0000 && enabled))
    else $error("continuous up did not restart");
  AST_STOP_HOLD: assert property (@(posedge mclk) disable iff (reset)
    (mode == MODE_STOP && enabled && !do_write) |=> $stable(counter_value_reg) && $stable(presc_cnt))
    else $error("stop mode changed state");
  AST_DISABLE_PRESC: assert property (@(posedge mclk) disable iff (reset)
    !enabled |=> presc_cnt == 7'h00)
    else $error("prescaler not reset");
  AST_STEP: assert property (@(posedge mclk) disable iff (reset)
    (tick && counter_value_reg != period_reg && !do_write)
    |=> counter_value_reg == 16'($past(counter_value_reg) + 16'h0001))
    else $error("counter step wrong");
  AST_DIR_UP: assert property (@(posedge mclk) disable iff (reset)
    up_mode |-> global_timer_control_reg[GCTL_DIR])
    else $error("direction bit not up");
  COV_SINGLE: cover property (@(posedge mclk) tick && mode == MODE_SINGLE_UP);
  COV_CONT: cover property (@(posedge mclk) tick && mode == MODE_CONT_UP);
  COV_ADC: cover property (@(posedge mclk) adc_q);
endmodule : gptuc_timer

/* File: shared/gptuc_pkg.sv */
// gptuc_pkg: register map, field positions and constants of the up-counting timer
package gptuc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_GLOBAL_CONTROL = 8'h04;
  localparam logic [7:0] OFS_COUNTER = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COMPARE = 8'h14;
  // ==========================================================
  // timer control fields
  localparam int CTL_OWN_PERIOD = 0;
  localparam int CTL_CMP_EN = 1;
  localparam int CTL_RELOAD_LO = 2;
  localparam int CTL_CLKSRC_LO = 4;
  localparam int CTL_ENABLE = 6;
  localparam int CTL_OWN_ENABLE = 7;
  localparam int CTL_PRESC_LO = 8;
  localparam int CTL_MODE_LO = 11;
  localparam int CTL_SOFT = 14;
  localparam int CTL_FREE = 15;
  // ==========================================================
  // global control fields
  localparam int GCTL_POL_LO = 0;
  localparam int GCTL_CMP_OUT_EN = 6;
  localparam int GCTL_DIR = 13;
  localparam int GCTL_ADC_LO = 7;
  localparam logic [1:0] ADC_NONE = 2'h0;
  localparam logic [1:0] ADC_UNDERFLOW = 2'h1;
  localparam logic [1:0] ADC_PERIOD = 2'h2;
  localparam logic [15:0] GCTL_WRITE_MASK = 16'h01FF;
  // ==========================================================
  // codes and resets
  localparam logic [2:0] MODE_STOP = 3'h0;
  localparam logic [2:0] MODE_SINGLE_UP = 3'h1;
  localparam logic [2:0] MODE_CONT_UP = 3'h2;
  localparam logic [1:0] CLK_INTERNAL = 2'h0;
  localparam logic [1:0] POL_FORCED_LOW = 2'h0;
  localparam logic [1:0] POL_ACTIVE_LOW = 2'h1;
  localparam logic [1:0] POL_ACTIVE_HIGH = 2'h2;
  localparam logic [15:0] RST_TIMER_CONTROL = 16'h0000;
  localparam logic [15:0] RST_GLOBAL_CONTROL = 16'h0000;
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam int FLAG_DELAY_CYCLES = 2;
  localparam int STAT_PERIOD = 0;
  localparam int STAT_UNDERFLOW = 1;
  localparam int STAT_OVERFLOW = 2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {GPTUC_W_IDLE, GPTUC_W_RESP} gptuc_wstate_t;
endpackage : gptuc_pkg

/* File: testbench/gptuc_timer_tb.sv */
// gptuc_timer_tb: self-checking bench of the up-counting timer
`timescale 1ns/1ps
module gptuc_timer_tb;
  import gptuc_pkg::*;
  // ==========
  // signals
  logic mclk, reset, external_clock, external_direction_pin;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, compare_out, adc_start;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, ediv;
  int errors, num_checks, cyc, cmp_high;
  int pulses[$];
  typedef struct {logic [15:0] gctl; logic [15:0] ctl; int gap;} gptuc_row_t;
  gptuc_row_t rows[5] = '{'{16'h0100, 16'h1040, 4}, '{16'h0080, 16'h1040, 4},
    '{16'h0100, 16'h1140, 8}, '{16'h0100, 16'h1240, 16}, '{16'h0100, 16'h1050, 16}};
  // polarity: active high, active low, forced low; high counts in ten periods of four
  logic [15:0] pol_g[3] = '{16'h0042, 16'h0041, 16'h0040};
  int pol_n[3] = '{30, 10, 0};
  // ==========
  // design
  gptuc_timer DUT (.mclk, .reset, .external_clock, .external_direction_pin,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .compare_out, .adc_start);
  // ==========
  // clocks, timeout, pulse log
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // external clock rises once every four cycles, the fastest allowed
  always @(posedge mclk)
  begin
    ediv <= ediv + 2'h1;
    external_clock <= ediv[1];
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      $display("timeout");
      close_out();
    end
  end
  // sampled mid-cycle so the registered pulse is settled
  always @(negedge mclk)
  begin
    if (adc_start === 1'b1)
      pulses.push_back(cyc);
    if (compare_out === 1'b1)
      cmp_high++;
  end
  // ==========
  // tasks
  task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check32
  task automatic check_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check_resp
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge mclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge mclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    logic ar, r;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r)
    begin
      @(negedge mclk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge mclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
  endtask : axi_read
  task automatic setup(input logic [15:0] cnt, input logic [15:0] per, input logic [15:0] g);
    axi_write(OFS_TIMER_CONTROL, 32'h0);
    axi_write(OFS_STATUS, 32'h7);
    axi_write(OFS_PERIOD, {16'h0, per});
    axi_write(OFS_COUNTER, {16'h0, cnt});
    axi_write(OFS_GLOBAL_CONTROL, {16'h0, g});
    pulses.delete();
  endtask : setup
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // ==========
  // main sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    external_direction_pin = 1'b1;
    ediv = 2'h0;
    external_clock = 1'b0;
    cyc = 0;
    errors = 0;
    num_checks = 0;
    reset = 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    // periodic cases: gap between adc pulses is (period+1) scaled clocks
    foreach (rows[i])
    begin
      setup(16'h0000, 16'h0003, rows[i].gctl);
      axi_write(OFS_TIMER_CONTROL, {16'h0, rows[i].ctl});
      repeat (rows[i].gap * 6) @(posedge mclk);
      for (int k = 1; k < pulses.size(); k++)
        check32("adc gap", rows[i].gap, pulses[k] - pulses[k-1]);
      check32("adc count", 1, pulses.size() >= 4);
      $display("row %0d done", i);
    end
    // compare set at count 0, cleared at period 3: high three counts of four
    setup(16'h0000, 16'h0003, 16'h0042);
    axi_write(OFS_COMPARE, 32'h0);
    axi_write(OFS_TIMER_CONTROL, 32'h1042);
    foreach (pol_g[p])
    begin
      axi_write(OFS_GLOBAL_CONTROL, {16'h0, pol_g[p]});
      repeat (4) @(posedge mclk);
      cmp_high = 0;
      repeat (40) @(posedge mclk);
      check32("compare high", pol_n[p], cmp_high);
    end
    $display("compare done");
    // single up from zero ends once and stays ended
    setup(16'h0000, 16'h0003, 16'h0100);
    axi_write(OFS_TIMER_CONTROL, 32'h0840);
    repeat (40) @(posedge mclk);
    check32("single pulses", 1, pulses.size());
    axi_read(OFS_TIMER_CONTROL);
    check32("single ctl", 32'h0800, rd);
    axi_read(OFS_COUNTER);
    check32("single cnt", 32'h0, rd);
    axi_read(OFS_STATUS);
    check32("single status", 32'h3, rd & 32'h7);
    $display("single up done");
    // start equal to period ends at once
    setup(16'h0003, 16'h0003, 16'h0000);
    axi_write(OFS_TIMER_CONTROL, 32'h0840);
    repeat (10) @(posedge mclk);
    axi_read(OFS_TIMER_CONTROL);
    check32("equal ctl", 32'h0800, rd);
    axi_read(OFS_STATUS);
    check32("equal status", 32'h3, rd & 32'h7);
    $display("equal start done");
    // start above period wraps through all ones; direction pin has no say
    setup(16'hFFFE, 16'h0003, 16'h0080);
    external_direction_pin <= 1'b0;
    axi_write(OFS_TIMER_CONTROL, 32'h1040);
    repeat (30) @(posedge mclk);
    axi_read(OFS_STATUS);
    check32("wrap status", 32'h7, rd & 32'h7);
    check32("wrap gap", 32'd4, pulses[1] - pulses[0]);
    axi_read(OFS_GLOBAL_CONTROL);
    check32("direction", 32'h1, rd[13]);
    $display("wrap done");
    // stop mode and disabled timer both hold the count
    setup(16'hABCD, 16'h0003, 16'h0000);
    axi_write(OFS_TIMER_CONTROL, 32'h0040);
    repeat (10) @(posedge mclk);
    axi_read(OFS_COUNTER);
    check32("stop cnt", 32'hABCD, rd);
    axi_write(OFS_TIMER_CONTROL, 32'h1000);
    repeat (10) @(posedge mclk);
    axi_read(OFS_COUNTER);
    check32("disabled cnt", 32'hABCD, rd);
    axi_write(8'h18, 32'h1);
    check_resp("unmapped write", AXI_SLVERR, rs);
    $display("hold done");
    // second reset restores the register defaults
    @(posedge mclk);
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    axi_read(OFS_TIMER_CONTROL);
    check32("rst ctl", {16'h0, RST_TIMER_CONTROL}, rd);
    axi_read(OFS_COUNTER);
    check32("rst cnt", {16'h0, RST_COUNTER}, rd);
    axi_read(OFS_PERIOD);
    check32("rst per", {16'h0, RST_PERIOD}, rd);
    axi_read(8'h18);
    check_resp("unmapped read", AXI_SLVERR, rs);
    $display("reset done");
    close_out();
  end
endmodule : gptuc_timer_tb
